// >>> hdl/tesw_pkg.sv
// Package with constants and types for the tape extended status word block.
`default_nettype none
package tesw_pkg;
	localparam int TESW_WORD_W = 16;
	// Bit positions of the extended status word.
	localparam int TESW_B_TMARK = 15;
	localparam int TESW_B_SHORT = 14;
	localparam int TESW_B_LEOT = 13;
	localparam int TESW_B_LONG = 12;
	localparam int TESW_B_WLERR = 11;
	localparam int TESW_B_NEXEC = 10;
	localparam int TESW_B_ILCMD = 9;
	localparam int TESW_B_ILADR = 8;
	localparam int TESW_B_MOTION = 7;
	localparam int TESW_B_ONLINE = 6;
	localparam int TESW_B_IEECHO = 5;
	localparam int TESW_B_VCHECK = 4;
	localparam int TESW_B_ZERO = 3;
	localparam int TESW_B_WPROT = 2;
	localparam int TESW_B_LOADPT = 1;
	localparam int TESW_B_ENDSTR = 0;
	// Position of this word in the message buffer, counted from one.
	localparam logic [2:0] TESW_MSG_WORD_POS = 3'h4;
	localparam logic [2:0] TESW_MSG_WORD_IDX = 3'h3;
	localparam logic [15:0] TESW_WORD_RESET = 16'h0000;
	localparam logic [2:0] TESW_TC_NORMAL = 3'h0;
	localparam logic [2:0] TESW_TC_ATTENTION_EVENT = 3'h1;
	localparam logic [2:0] TESW_TC_REJECT = 3'h3;
	// Command classes decoded by the command fetch logic.
	typedef enum logic [2:0] {
		TESW_CMD_OTHER = 3'b000,
		TESW_CMD_READ = 3'b001,
		TESW_CMD_WRITE = 3'b010,
		TESW_CMD_SPACE = 3'b011,
		TESW_CMD_SKIP = 3'b100,
		TESW_CMD_WMARK = 3'b101,
		TESW_CMD_STATUS = 3'b110,
		TESW_CMD_INIT = 3'b111
	} tesw_cmd_t;
endpackage
`default_nettype wire

// >>> hdl/tesw_status.sv
// Extended status word zero of the tape controller.
`default_nettype none
module tesw_status (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic nrst_i,
	// Transport status lines, asynchronous to the clock.
	input wire logic xport_online_i,
	input wire logic xport_power_ok_i,
	input wire logic xport_fmt_busy_i,
	input wire logic xport_rewinding_i,
	input wire logic xport_ring_absent_i,
	input wire logic xport_load_point_i,
	input wire logic xport_end_strip_i,
	input wire logic xport_tape_mark_i,
	// Command issue from the command fetch logic.
	input wire logic cmd_valid_i,
	input wire tesw_pkg::tesw_cmd_t cmd_class_i,
	input wire logic cmd_reverse_i,
	input wire logic cmd_motion_i,
	input wire logic cmd_code_bad_i,
	input wire logic cmd_addr_odd_i,
	input wire logic cmd_ie_i,
	input wire logic cmd_clear_volume_check_bit_i,
	input wire logic cmd_set_chars_i,
	input wire logic cmd_double_mark_stop_enable_i,
	// Record events from the data path.
	input wire logic rec_short_i,
	input wire logic rec_long_i,
	input wire logic count_left_i,
	input wire logic preread_i,
	input wire logic rec_requested_i,
	input wire logic cmd_done_i,
	// Message buffer word request.
	input wire logic msg_rd_i,
	input wire logic [2:0] msg_idx_i,
	input wire logic attention_enable_i,
	// Outputs.
	output logic [15:0] extended_status_word0_o,
	output logic msg_valid_o,
	output logic cmd_reject_o,
	output logic [2:0] termination_class_o,
	output logic attention_event_o,
	output logic skip_stop_o
);
	import tesw_pkg::*;

	tesw_sync_if sync();

	logic tmark;
	logic short_record_flag;
	logic leot;
	logic long_record_flag;
	logic write_lock_error_flag;
	logic non_executable_flag;
	logic illegal_command_flag;
	logic illegal_address_flag;
	logic interrupt_enable_echo;
	logic volume_check_flag;
	logic end_strip_flag;
	logic double_mark_stop_enable;
	logic end_pending;
	logic online_prev;
	logic mark_prev;
	logic strip_prev;
	logic first_rec;
	logic cur_rev;
	logic [2:0] settle;
	logic settled;
	logic online_chg;
	tesw_cmd_t cur_cmd;
	logic mark_rise;
	logic in_skip;
	logic double_mark;
	logic reject;
	logic vck_set;
	logic [15:0] word;

	tesw_sync #(
		.WIDTH(8)
	) u_sync (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.raw_i({xport_tape_mark_i, xport_end_strip_i, xport_load_point_i,
			xport_ring_absent_i, xport_rewinding_i, xport_fmt_busy_i,
			xport_power_ok_i, xport_online_i}),
		.sync(sync)
	);

	assign mark_rise = sync.tape_mark && !mark_prev;
	assign in_skip = (cur_cmd == TESW_CMD_SKIP);
	assign double_mark = mark_rise && first_rec;
	// off-line rejects all but status and initialize.
	assign reject = cmd_valid_i && (
		(!sync.online && cmd_class_i != TESW_CMD_STATUS && cmd_class_i != TESW_CMD_INIT) ||
		(cmd_reverse_i && sync.load_point) ||
		(cmd_motion_i && volume_check_flag) ||
		(cmd_class_i == TESW_CMD_WRITE && sync.ring_absent));
	// on-line change, ignored until the synchroniser holds real pin levels.
	assign online_chg = settled && (sync.online != online_prev);
	// volume check raised on off-line or power loss.
	assign vck_set = settled && ((!sync.online && online_prev) || !sync.power_ok);
	assign settled = settle[2];

	// The synchroniser resets to zero, so level changes seen before it refills are not real.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			settle <= '0;
		end else begin
			settle <= {settle[1:0], 1'b1};
		end
	end

	// Latches the active command and tracks tape mark edges.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cur_cmd <= TESW_CMD_OTHER;
			cur_rev <= 1'b0;
			mark_prev <= 1'b0;
			online_prev <= 1'b0;
			strip_prev <= 1'b0;
		end else begin
			mark_prev <= sync.tape_mark;
			online_prev <= sync.online;
			strip_prev <= sync.end_strip;
			if (cmd_valid_i && !reject) begin
				cur_cmd <= cmd_class_i;
				cur_rev <= cmd_reverse_i;
			end else if (cmd_done_i) begin
				cur_cmd <= TESW_CMD_OTHER;
				cur_rev <= 1'b0;
			end
		end
	end

	// Remembers whether the last thing passed was a tape mark or the load point.
	// Only short or long records count as data; a record of exact length is not seen.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			first_rec <= 1'b0;
		end else if (sync.load_point || mark_rise) begin
			first_rec <= 1'b1;
		end else if (rec_short_i || rec_long_i) begin
			first_rec <= 1'b0;
		end
	end

	// mode latched by a write-characteristics command.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			double_mark_stop_enable <= 1'b0;
		end else if (cmd_valid_i && cmd_set_chars_i) begin
			double_mark_stop_enable <= cmd_double_mark_stop_enable_i;
		end
	end

	// Command-ending flags; new command clears them, events in the same cycle still set.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tmark <= 1'b0;
			short_record_flag <= 1'b0;
			leot <= 1'b0;
			long_record_flag <= 1'b0;
		end else begin
			// tape mark during read, space, skip or mark write.
			tmark <= (tmark && !cmd_valid_i) || (mark_rise && (cur_cmd == TESW_CMD_READ ||
				cur_cmd == TESW_CMD_SPACE || in_skip || cur_cmd == TESW_CMD_WMARK));
			// short read, space or skip ended early.
			short_record_flag <= (short_record_flag && !cmd_valid_i) ||
				(cur_cmd == TESW_CMD_READ && rec_short_i) ||
				(cur_cmd == TESW_CMD_SPACE && count_left_i && (mark_rise || sync.load_point)) ||
				(in_skip && count_left_i && (sync.load_point ||
				(double_mark && double_mark_stop_enable)));
			// logical end only in skip. gated by the enabled mode.
			leot <= (leot && !cmd_valid_i) || (in_skip && double_mark && double_mark_stop_enable);
			long_record_flag <= (long_record_flag && !cmd_valid_i) ||
				(cur_cmd == TESW_CMD_READ && rec_long_i);
		end
	end

	// Issue-time checks, refreshed on every command.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			write_lock_error_flag <= 1'b0;
			non_executable_flag <= 1'b0;
			illegal_command_flag <= 1'b0;
			illegal_address_flag <= 1'b0;
			interrupt_enable_echo <= 1'b0;
			cmd_reject_o <= 1'b0;
		end else begin
			cmd_reject_o <= reject;
			if (cmd_valid_i) begin
				write_lock_error_flag <= (cmd_class_i == TESW_CMD_WRITE) && sync.ring_absent;
				// reverse at load point. volume check. off-line. write without ring.
				non_executable_flag <= reject;
				illegal_command_flag <= cmd_code_bad_i;
				illegal_address_flag <= cmd_addr_odd_i;
				interrupt_enable_echo <= cmd_ie_i;
			end
		end
	end

	// volume check set by hardware; set wins over host clear.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			volume_check_flag <= 1'b0;
		end else if (vck_set) begin
			volume_check_flag <= 1'b1;
		end else if (cmd_valid_i && cmd_clear_volume_check_bit_i) begin
			volume_check_flag <= 1'b0;
		end
	end

	// end strip flag held until a reverse crossing.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			end_strip_flag <= 1'b0;
			end_pending <= 1'b0;
		end else begin
			if (sync.end_strip && preread_i && !end_strip_flag) begin
				end_pending <= 1'b1;
			end else if (end_pending && rec_requested_i) begin
				end_pending <= 1'b0;
			end
			if ((sync.end_strip && !preread_i) || (end_pending && rec_requested_i)) begin
				end_strip_flag <= 1'b1;
			// Clears as the strip slides off the head under a reverse command.
			end else if (strip_prev && !sync.end_strip && cur_rev) begin
				end_strip_flag <= 1'b0;
			end
		end
	end

	// motion. on-line. zero bit. write protect. load point.
	always_comb begin
		word = TESW_WORD_RESET;
		word[TESW_B_TMARK] = tmark;
		word[TESW_B_SHORT] = short_record_flag;
		word[TESW_B_LEOT] = leot;
		word[TESW_B_LONG] = long_record_flag;
		word[TESW_B_WLERR] = write_lock_error_flag;
		word[TESW_B_NEXEC] = non_executable_flag;
		word[TESW_B_ILCMD] = illegal_command_flag;
		word[TESW_B_ILADR] = illegal_address_flag;
		word[TESW_B_MOTION] = sync.fmt_busy || sync.rewinding;
		word[TESW_B_ONLINE] = sync.online;
		word[TESW_B_IEECHO] = interrupt_enable_echo;
		word[TESW_B_VCHECK] = volume_check_flag;
		word[TESW_B_ZERO] = 1'b0;
		word[TESW_B_WPROT] = sync.ring_absent;
		word[TESW_B_LOADPT] = sync.load_point;
		word[TESW_B_ENDSTR] = end_strip_flag;
	end

	// word offered at the fourth message slot.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			extended_status_word0_o <= TESW_WORD_RESET;
			msg_valid_o <= 1'b0;
		end else begin
			msg_valid_o <= msg_rd_i && (msg_idx_i == TESW_MSG_WORD_IDX);
			if (msg_rd_i && msg_idx_i == TESW_MSG_WORD_IDX) begin
				extended_status_word0_o <= word;
			end
		end
	end

	// attention on on-line change. reject class 3.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			termination_class_o <= TESW_TC_NORMAL;
			attention_event_o <= 1'b0;
			skip_stop_o <= 1'b0;
		end else begin
			attention_event_o <= attention_enable_i && online_chg;
			skip_stop_o <= in_skip && double_mark && double_mark_stop_enable;
			if (reject) begin
				termination_class_o <= TESW_TC_REJECT;
			end else if (attention_enable_i && online_chg) begin
				termination_class_o <= TESW_TC_ATTENTION_EVENT;
			end else if (cmd_valid_i) begin
				termination_class_o <= TESW_TC_NORMAL;
			end
		end
	end

	a_zero_bit: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!extended_status_word0_o[TESW_B_ZERO])
		else $error("Reserved status bit is not zero");

	a_offline_reject: assert property (@(posedge clock_i) disable iff (!nrst_i)
		cmd_valid_i && !sync.online && cmd_class_i == TESW_CMD_READ |=> non_executable_flag)
		else $error("Off-line command not flagged non-executable");

	a_wlock_pair: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_lock_error_flag |-> non_executable_flag)
		else $error("Write lock error without non-executable flag");

	a_reject_class: assert property (@(posedge clock_i) disable iff (!nrst_i)
		reject |=> termination_class_o == TESW_TC_REJECT && cmd_reject_o)
		else $error("Rejected command lacks class 3");

	a_leot_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$rose(leot) |-> $past(double_mark_stop_enable))
		else $error("Logical end set without enabled mode");

	a_vck_set: assert property (@(posedge clock_i) disable iff (!nrst_i)
		vck_set |=> volume_check_flag)
		else $error("Volume check not set on off-line");

	a_ie_echo: assert property (@(posedge clock_i) disable iff (!nrst_i)
		cmd_valid_i |=> interrupt_enable_echo == $past(cmd_ie_i))
		else $error("Interrupt enable echo wrong");

	a_msg_slot: assert property (@(posedge clock_i) disable iff (!nrst_i)
		msg_rd_i && msg_idx_i == TESW_MSG_WORD_IDX |=> msg_valid_o
		&& extended_status_word0_o == $past(word))
		else $error("Status word not delivered at fourth slot");
endmodule
`default_nettype wire

// >>> hdl/tesw_sync.sv
// Two-stage synchroniser for the transport status lines.
`default_nettype none
module tesw_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic nrst_i,
	// Raw transport lines.
	input wire logic [WIDTH-1:0] raw_i,
	// Synchronised lines.
	tesw_sync_if.src sync
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= raw_i;
			stage2 <= stage1;
		end
	end

	assign sync.online = stage2[0];
	assign sync.power_ok = stage2[1];
	assign sync.fmt_busy = stage2[2];
	assign sync.rewinding = stage2[3];
	assign sync.ring_absent = stage2[4];
	assign sync.load_point = stage2[5];
	assign sync.end_strip = stage2[6];
	assign sync.tape_mark = stage2[7];
endmodule
`default_nettype wire

// >>> hdl/tesw_sync_if.sv
// Interface carrying synchronised transport status lines.
`default_nettype none
interface tesw_sync_if;
	logic online;
	logic power_ok;
	logic fmt_busy;
	logic rewinding;
	logic ring_absent;
	logic load_point;
	logic end_strip;
	logic tape_mark;
	modport src (output online, power_ok, fmt_busy, rewinding, ring_absent, load_point,
		end_strip, tape_mark);
	modport dst (input online, power_ok, fmt_busy, rewinding, ring_absent, load_point,
		end_strip, tape_mark);
endinterface
`default_nettype wire

// >>> tb/test_tesw_status.sv
// Self-checking bench for the extended status word block.
`default_nettype none
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
module test_tesw_status;
	import tesw_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic on = 1'b1, pwr = 1'b1, ring = 1'b1, go = 1'b0, mark = 1'b0;
	logic x_on, x_pwr, x_busy, x_rew, x_ring, x_lp, x_end, x_mark;
	logic cmd_valid_i = 1'b0, rev = 1'b0, mot = 1'b0, bad = 1'b0, odd = 1'b0;
	logic ie = 1'b0, clear_volume_check_bit = 1'b0, set_chars = 1'b0, dms = 1'b0;
	tesw_cmd_t cls = TESW_CMD_OTHER;
	logic rec_short = 1'b0, rec_long = 1'b0, cmd_done = 1'b0, attention_event_en = 1'b1;
	logic msg_rd_i = 1'b0;
	logic left = 1'b0, pre = 1'b0, rec_req = 1'b0, strip = 1'b0;
	logic [2:0] msg_idx_i = 3'h0;
	logic [15:0] extended_status_word0_o;
	logic msg_valid_o, cmd_reject_o, attention_event_o, skip_stop_o;
	logic [2:0] termination_class_o;
	int num_errors = 0;
	int checks = 0;
	int stops = 0;
	initial forever #2 clock_i = ~clock_i;
	always @(posedge clock_i)
		if (skip_stop_o === 1'b1)
			stops <= stops + 1;
	tesw_xport_model tesw_xport_model_inst (.clock_i(clock_i), .online_i(on), .power_i(pwr),
		.ring_i(ring), .go_i(go), .mark_i(mark), .strip_i(strip), .online_o(x_on),
		.power_ok_o(x_pwr), .fmt_busy_o(x_busy), .rewinding_o(x_rew), .ring_absent_o(x_ring),
		.load_point_o(x_lp), .end_strip_o(x_end), .tape_mark_o(x_mark));
	tesw_status tesw_status_inst (.clock_i(clock_i), .nrst_i(nrst_i), .xport_online_i(x_on),
		.xport_power_ok_i(x_pwr), .xport_fmt_busy_i(x_busy), .xport_rewinding_i(x_rew),
		.xport_ring_absent_i(x_ring), .xport_load_point_i(x_lp), .xport_end_strip_i(x_end),
		.xport_tape_mark_i(x_mark), .cmd_valid_i(cmd_valid_i), .cmd_class_i(cls),
		.cmd_reverse_i(rev), .cmd_motion_i(mot), .cmd_code_bad_i(bad), .cmd_addr_odd_i(odd),
		.cmd_ie_i(ie), .cmd_clear_volume_check_bit_i(clear_volume_check_bit), .cmd_set_chars_i(set_chars),
		.cmd_double_mark_stop_enable_i(dms), .rec_short_i(rec_short), .rec_long_i(rec_long),
		.count_left_i(left), .preread_i(pre), .rec_requested_i(rec_req),
		.cmd_done_i(cmd_done), .msg_rd_i(msg_rd_i), .msg_idx_i(msg_idx_i),
		.attention_enable_i(attention_event_en), .extended_status_word0_o(extended_status_word0_o),
		.msg_valid_o(msg_valid_o), .cmd_reject_o(cmd_reject_o),
		.termination_class_o(termination_class_o), .attention_event_o(attention_event_o),
		.skip_stop_o(skip_stop_o));
	task automatic final_report();
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Issues one command and checks the refusal pulse and the class that follows it.
	task automatic issue(input tesw_cmd_t c, input logic [5:0] f, input logic rej,
		input logic [2:0] tc);
		@(negedge clock_i);
		cmd_valid_i = 1'b1;
		cls = c;
		{rev, mot, bad, odd, ie, clear_volume_check_bit} = f;
		@(negedge clock_i);
		cmd_valid_i = 1'b0;
		`CHK("cmd_reject_o", rej, cmd_reject_o)
		`CHK("termination_class_o", tc, termination_class_o)
	endtask
	task automatic word(input logic [15:0] exp, input logic [15:0] mask = 16'hFFFF);
		@(negedge clock_i);
		msg_rd_i = 1'b1;
		msg_idx_i = TESW_MSG_WORD_IDX;
		@(negedge clock_i);
		msg_rd_i = 1'b0;
		`CHK("msg_valid_o", 1'b1, msg_valid_o)
		`CHK("extended_status_word0_o", exp, extended_status_word0_o & mask)
	endtask
	// Raises one strobe for a clock: 0 go, 1 long, 2 short, 3 done, 4 record request.
	task automatic pulse(input int sel);
		@(negedge clock_i);
		{go, rec_long, rec_short, cmd_done, rec_req} = 5'h10 >> sel;
		@(negedge clock_i);
		{go, rec_long, rec_short, cmd_done, rec_req} = 5'h00;
	endtask
	task automatic wait_attention_event();
		logic seen;
		seen = 1'b0;
		repeat (6) begin
			@(negedge clock_i);
			if (attention_event_o === 1'b1)
				seen = 1'b1;
		end
		`CHK("attention_event_o", 1'b1, seen)
		`CHK("termination_class_o", TESW_TC_ATTENTION_EVENT, termination_class_o)
	endtask
	initial begin
		#(4 * 20000);
		num_errors++;
		final_report();
	end
	initial begin
		repeat (12) @(negedge clock_i);
		nrst_i = 1'b1;
		repeat (6) @(negedge clock_i);
		`CHK("termination_class_o", TESW_TC_NORMAL, termination_class_o)
		`CHK("attention_event_o", 1'b0, attention_event_o)
		issue(TESW_CMD_STATUS, 6'b000000, 1'b0, TESW_TC_NORMAL);
		word(16'h0042);
		@(negedge clock_i);
		msg_rd_i = 1'b1;
		msg_idx_i = 3'h2;
		@(negedge clock_i);
		msg_rd_i = 1'b0;
		`CHK("msg_valid_o", 1'b0, msg_valid_o)
		issue(TESW_CMD_SPACE, 6'b110000, 1'b1, TESW_TC_REJECT);
		word(16'h0442);
		issue(TESW_CMD_STATUS, 6'b001110, 1'b0, TESW_TC_NORMAL);
		word(16'h0362);
		issue(TESW_CMD_READ, 6'b010000, 1'b0, TESW_TC_NORMAL);
		mark = 1'b1;
		pulse(0);
		repeat (3) @(negedge clock_i);
		word(16'h0080, 16'h0080);
		pulse(1);
		repeat (10) @(negedge clock_i);
		word(16'h9040);
		mark = 1'b0;
		issue(TESW_CMD_READ, 6'b010000, 1'b0, TESW_TC_NORMAL);
		pulse(2);
		word(16'h4040);
		pulse(3);
		@(negedge clock_i);
		on = 1'b0;
		wait_attention_event();
		issue(TESW_CMD_READ, 6'b010000, 1'b1, TESW_TC_REJECT);
		word(16'h0410);
		issue(TESW_CMD_STATUS, 6'b000001, 1'b0, TESW_TC_NORMAL);
		issue(TESW_CMD_INIT, 6'b000001, 1'b0, TESW_TC_NORMAL);
		word(16'h0000);
		on = 1'b1;
		wait_attention_event();
		ring = 1'b0;
		repeat (4) @(negedge clock_i);
		issue(TESW_CMD_WRITE, 6'b010000, 1'b1, TESW_TC_REJECT);
		word(16'h0C44);
		ring = 1'b1;
		pwr = 1'b0;
		repeat (4) @(negedge clock_i);
		pwr = 1'b1;
		repeat (4) @(negedge clock_i);
		issue(TESW_CMD_SPACE, 6'b010000, 1'b1, TESW_TC_REJECT);
		word(16'h0450);
		issue(TESW_CMD_STATUS, 6'b000001, 1'b0, TESW_TC_NORMAL);
		word(16'h0040);
		issue(TESW_CMD_WMARK, 6'b010000, 1'b0, TESW_TC_NORMAL);
		mark = 1'b1;
		pulse(0);
		repeat (10) @(negedge clock_i);
		word(16'h8040);
		issue(TESW_CMD_SKIP, 6'b010000, 1'b0, TESW_TC_NORMAL);
		pulse(0);
		repeat (10) @(negedge clock_i);
		word(16'h8040);
		`CHK("skip_stop_o", 0, stops)
		set_chars = 1'b1;
		dms = 1'b1;
		issue(TESW_CMD_OTHER, 6'b000000, 1'b0, TESW_TC_NORMAL);
		set_chars = 1'b0;
		left = 1'b1;
		issue(TESW_CMD_SKIP, 6'b010000, 1'b0, TESW_TC_NORMAL);
		pulse(0);
		repeat (10) @(negedge clock_i);
		word(16'hE040);
		`CHK("skip_stop_o", 1, stops)
		mark = 1'b0;
		left = 1'b0;
		pre = 1'b1;
		strip = 1'b1;
		repeat (4) @(negedge clock_i);
		strip = 1'b0;
		repeat (4) @(negedge clock_i);
		pre = 1'b0;
		word(16'h0000, 16'h0001);
		pulse(4);
		word(16'h0001, 16'h0001);
		issue(TESW_CMD_SPACE, 6'b110000, 1'b0, TESW_TC_NORMAL);
		word(16'h0001, 16'h0001);
		strip = 1'b1;
		repeat (4) @(negedge clock_i);
		strip = 1'b0;
		repeat (4) @(negedge clock_i);
		word(16'h0000, 16'h0001);
		final_report();
	end
endmodule
`default_nettype wire

// >>> tb/tesw_xport_model.sv
// Behavioural tape transport that drives the status lines seen by the controller.
`default_nettype none
module tesw_xport_model #(
	parameter int BUSY_CYC = 8
) (
	// Clock.
	input wire logic clock_i,
	// Bench controls.
	input wire logic online_i,
	input wire logic power_i,
	input wire logic ring_i,
	input wire logic go_i,
	input wire logic mark_i,
	input wire logic strip_i,
	// Transport status lines.
	output logic online_o,
	output logic power_ok_o,
	output logic fmt_busy_o,
	output logic rewinding_o,
	output logic ring_absent_o,
	output logic load_point_o,
	output logic end_strip_o,
	output logic tape_mark_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial load_point_o = 1'b1;
	always @(posedge clock_i) begin
		if (go_i)
			cnt <= BUSY_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	always @(posedge clock_i) begin
		if (go_i)
			load_point_o <= 1'b0;
	end
	assign fmt_busy_o = (cnt > 0);
	assign tape_mark_o = mark_i && (cnt > 2) && (cnt < 7);
	assign online_o = online_i;
	assign power_ok_o = power_i;
	assign ring_absent_o = !ring_i;
	assign rewinding_o = 1'b0;
	// the bench places the end strip under the head.
	assign end_strip_o = strip_i;
endmodule
`default_nettype wire
